// >>> design/osm_cfg.svh
`ifndef OSM_CFG_SVH
`define OSM_CFG_SVH

// ****************************************************************
// Register select codes
// ****************************************************************
`define OSM_SEL_W          2
`define OSM_SEL_DCACHE     2'h0
`define OSM_SEL_LIN        2'h1
`define OSM_SEL_PHYS       2'h2
`define OSM_SEL_BRT        2'h3

// ****************************************************************
// Cache sample register fields
// ****************************************************************
`define OSM_LAT_HI         47
`define OSM_LAT_LO         32
`define OSM_LAT_W          16
`define OSM_PHYS_VAL_BIT   18
`define OSM_LIN_VAL_BIT    17
`define OSM_LOCKED_BIT     15
`define OSM_UC_BIT         14
`define OSM_WC_BIT         13
`define OSM_MISALIGN_BIT   8
`define OSM_MISS_BIT       7
`define OSM_TLB1G_BIT      5
`define OSM_TLB2M_BIT      4
`define OSM_TLBMISS_BIT    2
`define OSM_STORE_BIT      1
`define OSM_LOAD_BIT       0
`define OSM_DCACHE_MASK    64'h0000_ffff_0006_e1b7

// ****************************************************************
// Address widths, masks and reset values
// ****************************************************************
`define OSM_PHYS_W         52
`define OSM_PHYS_MASK      64'h000f_ffff_ffff_ffff
`define OSM_VA_MSB         47
`define OSM_RESET_WORD     64'h0000_0000_0000_0000
`define OSM_LAT_MAX        16'hffff

`endif

// >>> design/osm_pkg.sv
package osm_pkg;

  // Data word of every capture register
  typedef logic [63:0] osm_word_t;

  // Miss latency counter states
  typedef enum logic [0:0] {
    OSM_LAT_IDLE,
    OSM_LAT_COUNT
  } osm_lat_state_t;

endpackage

// >>> design/osm_miss_latency.sv
`timescale 1ns/1ps
`default_nettype none
`include "osm_cfg.svh"

module osm_miss_latency
  import osm_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Data cache miss events
  input  wire logic                   miss_detect_i,
  input  wire logic                   miss_upper_i,
  input  wire logic                   data_return_i,
  input  wire logic                   return_upper_i,
  input  wire logic                   new_op_i,
  // Latency result
  output logic [`OSM_LAT_W-1:0]       latency_o
);

  osm_lat_state_t         state_reg;
  logic [`OSM_LAT_W-1:0]  count_reg;

  // Track one lower-part miss from detection to delivery
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= OSM_LAT_IDLE;
    end else begin
      unique case (state_reg)
        OSM_LAT_IDLE: begin
          if (miss_detect_i && !miss_upper_i) begin
            state_reg <= OSM_LAT_COUNT;
          end
        end
        OSM_LAT_COUNT: begin
          if (data_return_i && !return_upper_i) begin
            state_reg <= OSM_LAT_IDLE;
          end
        end
      endcase
    end
  end

  // Count core cycles while the miss is outstanding, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else if (new_op_i) begin
      count_reg <= '0;
    end else if (miss_detect_i && !miss_upper_i && state_reg == OSM_LAT_IDLE) begin
      count_reg <= '0;
    end else if (state_reg == OSM_LAT_COUNT && !(data_return_i && !return_upper_i)) begin
      if (count_reg != `OSM_LAT_MAX) begin
        count_reg <= count_reg + 16'h1;
      end
    end
  end

  assign latency_o = count_reg;

  lat_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    new_op_i |=> count_reg == 16'h0)
    else $error("latency not cleared on new op");

endmodule
`default_nettype wire

// >>> design/osm_capture_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "osm_cfg.svh"

// Functional notes
// - Across a 128-bit boundary, only the lower part's cache data is recorded.
// - Bits 47:32 hold core cycles from data cache miss to data delivery.
// - Miss latency is not meaningful for stores; stores record zero.
// - Bit 18 set only when the captured physical address is valid.
// - Bit 17 set only when the captured linear address is valid.
// - Bit 15 set when the sampled access was locked.
// - Bit 14 set when the access targeted uncacheable memory.
// - Bit 13 set when the access targeted write-combining memory.
// - Bit 8 set when a misaligned access cost a penalty.
// - Bit 7 set when the line was absent from the first-level data cache.
// - Bit 5 set on a 1-Gbyte page hit in the data-side L1 TLB.
// - Bit 4 set on a 2-Mbyte page hit in the data-side L1 TLB.
// - Bit 2 set when the translation missed the data-side L1 TLB.
// - Bit 1 marks a store, bit 0 marks a load.
// - Linear address register holds the operand address in canonical form.
// - Physical address in bits 51:0, bits 63:52 held at zero.
// - Branch target is canonical; zero means no valid target.
// - A not-taken conditional branch records its fall-through address.
// - Retirement of the tagged op writes the registers and sets sample valid on the same clock edge.
// - An op that aborts leaves the registers untouched.

module osm_capture_regs
  import osm_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Tagged op lifecycle
  input  wire logic                     op_tagged_i,
  input  wire logic                     op_retire_i,
  input  wire logic                     op_abort_i,
  input  wire logic                     sample_valid_clr_i,
  // Access type and memory attributes (lower part of the access)
  input  wire logic                     load_op_flag_i,
  input  wire logic                     store_op_flag_i,
  input  wire logic                     locked_access_flag_i,
  input  wire logic                     uncacheable_access_flag_i,
  input  wire logic                     write_combining_access_flag_i,
  input  wire logic                     misaligned_penalty_flag_i,
  input  wire logic                     cache_miss_flag_i,
  input  wire logic                     tlb_hit_1g_page_i,
  input  wire logic                     tlb_hit_2m_page_i,
  input  wire logic                     tlb_miss_flag_i,
  // Miss timing events from the data cache
  input  wire logic                     miss_detect_i,
  input  wire logic                     miss_upper_i,
  input  wire logic                     data_return_i,
  input  wire logic                     return_upper_i,
  // Operand addresses
  input  wire logic [63:0]              lin_addr_i,
  input  wire logic                     lin_addr_valid_i,
  input  wire logic [`OSM_PHYS_W-1:0]   phys_addr_i,
  input  wire logic                     phys_addr_valid_i,
  // Branch information
  input  wire logic                     branch_op_i,
  input  wire logic                     branch_cond_not_taken_i,
  input  wire logic [63:0]              branch_target_i,
  input  wire logic [63:0]              fall_through_i,
  // Software register port
  input  wire logic [`OSM_SEL_W-1:0]    reg_sel_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [63:0]              reg_wdata_i,
  output logic [63:0]                   reg_rdata_o,
  output logic                          reg_rvalid_o,
  // Sample status
  output logic                          sample_valid_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Sign-extend bit 47 into the upper bits for canonical form
  function automatic osm_word_t canon(input osm_word_t a);
    canon = {{16{a[`OSM_VA_MSB]}}, a[`OSM_VA_MSB:0]};
  endfunction

  // ****************************************************************
  // Storage and next values
  // ****************************************************************

  osm_word_t               dcache_info_reg;
  osm_word_t               lin_addr_reg;
  osm_word_t               phys_addr_reg;
  osm_word_t               brt_reg;
  osm_word_t               dcache_info_next;
  osm_word_t               brt_next;
  osm_word_t               rdata_reg;
  logic                    rvalid_reg;
  logic                    sample_valid_reg;
  logic                    capture;
  logic [`OSM_LAT_W-1:0]   miss_latency_cycles;
  logic [`OSM_LAT_W-1:0]   lat_field;

  // A sample is taken only when the tagged op retires without abort
  assign capture = op_retire_i && !op_abort_i;

  // Miss latency counter for the lower part of the access
  osm_miss_latency u_lat (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .miss_detect_i  (miss_detect_i),
    .miss_upper_i   (miss_upper_i),
    .data_return_i  (data_return_i),
    .return_upper_i (return_upper_i),
    .new_op_i       (op_tagged_i),
    .latency_o      (miss_latency_cycles)
  );

  // Stores record zero latency; only lower-part misses feed the count
  assign lat_field = (store_op_flag_i || !cache_miss_flag_i) ? '0 : miss_latency_cycles;

  // Assemble the cache sample word, every defined flag rewritten
  always_comb begin
    dcache_info_next                         = `OSM_RESET_WORD;
    dcache_info_next[`OSM_LAT_HI:`OSM_LAT_LO] = lat_field;
    dcache_info_next[`OSM_PHYS_VAL_BIT]      = phys_addr_valid_i;
    dcache_info_next[`OSM_LIN_VAL_BIT]       = lin_addr_valid_i;
    dcache_info_next[`OSM_LOCKED_BIT]        = locked_access_flag_i;
    dcache_info_next[`OSM_UC_BIT]            = uncacheable_access_flag_i;
    dcache_info_next[`OSM_WC_BIT]            = write_combining_access_flag_i;
    dcache_info_next[`OSM_MISALIGN_BIT]      = misaligned_penalty_flag_i;
    dcache_info_next[`OSM_MISS_BIT]          = cache_miss_flag_i;
    dcache_info_next[`OSM_TLB1G_BIT]         = tlb_hit_1g_page_i;
    dcache_info_next[`OSM_TLB2M_BIT]         = tlb_hit_2m_page_i;
    dcache_info_next[`OSM_TLBMISS_BIT]       = tlb_miss_flag_i;
    dcache_info_next[`OSM_STORE_BIT]         = store_op_flag_i;
    dcache_info_next[`OSM_LOAD_BIT]          = load_op_flag_i;
  end

  // Branch target selection: fall-through, taken target or zero
  always_comb begin
    if (!branch_op_i) begin
      brt_next = `OSM_RESET_WORD;
    end else if (branch_cond_not_taken_i) begin
      brt_next = canon(fall_through_i);
    end else begin
      brt_next = canon(branch_target_i);
    end
  end

  // ****************************************************************
  // Capture registers
  // ****************************************************************

  // Cache sample register; a sample wins over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dcache_info_reg <= `OSM_RESET_WORD;
    end else if (capture) begin
      dcache_info_reg <= dcache_info_next;
    end else if (reg_wr_i && reg_sel_i == `OSM_SEL_DCACHE) begin
      dcache_info_reg <= reg_wdata_i & `OSM_DCACHE_MASK;
    end
  end

  // Linear address register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lin_addr_reg <= `OSM_RESET_WORD;
    end else if (capture) begin
      lin_addr_reg <= canon(lin_addr_i);
    end else if (reg_wr_i && reg_sel_i == `OSM_SEL_LIN) begin
      lin_addr_reg <= reg_wdata_i;
    end
  end

  // Physical address register, upper bits held at zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phys_addr_reg <= `OSM_RESET_WORD;
    end else if (capture) begin
      phys_addr_reg <= {12'h000, phys_addr_i};
    end else if (reg_wr_i && reg_sel_i == `OSM_SEL_PHYS) begin
      phys_addr_reg <= reg_wdata_i & `OSM_PHYS_MASK;
    end
  end

  // Branch target register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      brt_reg <= `OSM_RESET_WORD;
    end else if (capture) begin
      brt_reg <= brt_next;
    end else if (reg_wr_i && reg_sel_i == `OSM_SEL_BRT) begin
      brt_reg <= reg_wdata_i;
    end
  end

  // Sample valid flag; setting wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sample_valid_reg <= 1'b0;
    end else if (capture) begin
      sample_valid_reg <= 1'b1;
    end else if (sample_valid_clr_i) begin
      sample_valid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= `OSM_RESET_WORD;
    end else if (reg_rd_i) begin
      unique case (reg_sel_i)
        `OSM_SEL_DCACHE: rdata_reg <= dcache_info_reg;
        `OSM_SEL_LIN:    rdata_reg <= lin_addr_reg;
        `OSM_SEL_PHYS:   rdata_reg <= phys_addr_reg;
        `OSM_SEL_BRT:    rdata_reg <= brt_reg;
      endcase
    end
  end

  // Read answer strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_i;
    end
  end

  assign reg_rdata_o    = rdata_reg;
  assign reg_rvalid_o   = rvalid_reg;
  assign sample_valid_o = sample_valid_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************

  no_abort_update_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (op_retire_i && op_abort_i && !reg_wr_i) |=> $stable(lin_addr_reg) && $stable(brt_reg))
    else $error("capture registers changed on aborted op");

  valid_after_retire_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    capture |=> sample_valid_reg && dcache_info_reg == $past(dcache_info_next))
    else $error("sample valid or data missing after retire");

  phys_upper_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    phys_addr_reg[63:52] == 12'h000)
    else $error("physical address upper bits not zero");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (dcache_info_reg & ~`OSM_DCACHE_MASK) == `OSM_RESET_WORD)
    else $error("reserved cache sample bits set");

  store_latency_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (capture && store_op_flag_i) |=> dcache_info_reg[`OSM_LAT_HI:`OSM_LAT_LO] == 16'h0)
    else $error("store recorded miss latency");

  type_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    capture |=> dcache_info_reg[1:0] == $past({store_op_flag_i, load_op_flag_i}))
    else $error("load or store flag wrong");

  addr_valid_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    capture |=> dcache_info_reg[18:17] == $past({phys_addr_valid_i, lin_addr_valid_i}))
    else $error("address valid flags wrong");

  lin_canonical_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    capture |=> lin_addr_reg[63:47] == {17{lin_addr_reg[47]}})
    else $error("linear address not canonical");

  fall_through_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (capture && branch_op_i && branch_cond_not_taken_i)
      |=> brt_reg == canon($past(fall_through_i)))
    else $error("fall-through address not recorded");

  no_branch_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (capture && !branch_op_i) |=> brt_reg == 64'h0)
    else $error("branch target not zero for non-branch");

  sw_write_holds_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_sel_i == `OSM_SEL_BRT && !capture)
      ##1 (!capture && !reg_wr_i) |=> brt_reg == $past(reg_wdata_i, 2))
    else $error("software value lost without new sample");

  load_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (capture && cache_miss_flag_i && !store_op_flag_i)
      |=> dcache_info_reg[`OSM_LAT_HI:`OSM_LAT_LO] == $past(miss_latency_cycles))
    else $error("miss latency not recorded");

  tlb_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    capture |=> dcache_info_reg[5:4] == $past({tlb_hit_1g_page_i, tlb_hit_2m_page_i})
      && dcache_info_reg[`OSM_TLBMISS_BIT] == $past(tlb_miss_flag_i))
    else $error("TLB flags wrong");

  read_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered in one cycle");

endmodule
`default_nettype wire

// >>> tb/osm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "osm_cfg.svh"

// ****************************************************************
// Core side model: pipeline, data cache and TLB feeding one sample
// ****************************************************************
module osm_core_model
  import osm_pkg::*;
(
  // Clock
  input  wire logic                   clk_i,
  // Op lifecycle
  output logic                        op_tagged_i, op_retire_i, op_abort_i,
  // Access flags
  output logic                        load_op_flag_i, store_op_flag_i, locked_access_flag_i,
  output logic                        uncacheable_access_flag_i, write_combining_access_flag_i,
  output logic                        misaligned_penalty_flag_i, cache_miss_flag_i,
  output logic                        tlb_hit_1g_page_i, tlb_hit_2m_page_i, tlb_miss_flag_i,
  // Miss timing events
  output logic                        miss_detect_i, miss_upper_i, data_return_i, return_upper_i,
  // Addresses and branch
  output logic [63:0]                 lin_addr_i,
  output logic                        lin_addr_valid_i,
  output logic [`OSM_PHYS_W-1:0]      phys_addr_i,
  output logic                        phys_addr_valid_i,
  output logic                        branch_op_i, branch_cond_not_taken_i,
  output logic [63:0]                 branch_target_i, fall_through_i
);
  // Idle lines at time zero
  initial begin
    {op_tagged_i, op_retire_i, op_abort_i} = 3'h0;
    {miss_detect_i, miss_upper_i, data_return_i, return_upper_i} = 4'h0;
    set_op(10'h0, 1'b0, 1'b0, 64'h0, 52'h0, 1'b0, 1'b0, 64'h0, 64'h0);
  end

  // Drive the values that qualify a retire
  task automatic set_op(input logic [9:0] f, input logic lv, pv, input logic [63:0] la,
                        input logic [51:0] pa, input logic br, nt, input logic [63:0] bt, ft);
    {load_op_flag_i, store_op_flag_i, locked_access_flag_i, uncacheable_access_flag_i,
     write_combining_access_flag_i, misaligned_penalty_flag_i, cache_miss_flag_i,
     tlb_hit_1g_page_i, tlb_hit_2m_page_i, tlb_miss_flag_i} = f;
    {lin_addr_valid_i, phys_addr_valid_i, lin_addr_i, phys_addr_i} = {lv, pv, la, pa};
    {branch_op_i, branch_cond_not_taken_i, branch_target_i, fall_through_i} = {br, nt, bt, ft};
  endtask

  // Tag, optional lower-part miss lasting lat cycles of upper-part events, then retire or abort
  task automatic run_op(input logic [9:0] f, input int lat, input logic ab, lv, pv,
                        input logic [63:0] la, input logic [51:0] pa,
                        input logic br, nt, input logic [63:0] bt, ft);
    logic [31:0] r;
    @(negedge clk_i) op_tagged_i = 1'b1;
    @(negedge clk_i) op_tagged_i = 1'b0;
    if (f[3]) begin
      miss_detect_i = 1'b1;
      @(negedge clk_i) miss_detect_i = 1'b0;
      repeat (lat) begin
        r = $urandom;
        // Upper-part events that must not disturb the count
        {miss_detect_i, miss_upper_i, data_return_i, return_upper_i} = {r[0], r[0], r[1], r[1]};
        @(negedge clk_i);
      end
      {miss_detect_i, miss_upper_i, data_return_i, return_upper_i} = 4'h2;
      @(negedge clk_i) data_return_i = 1'b0;
    end
    set_op(f, lv, pv, la, pa, br, nt, bt, ft);
    op_retire_i = 1'b1;
    op_abort_i = ab;
    @(negedge clk_i) {op_retire_i, op_abort_i} = 2'h0;
    // Released lines show the inverse of the last value
    set_op(~f, ~lv, ~pv, ~la, ~pa, ~br, ~nt, ~bt, ~ft);
  endtask
endmodule
`default_nettype wire

// >>> tb/op_sample_memory_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "osm_cfg.svh"

// ****************************************************************
// Testbench top
// ****************************************************************
module op_sample_memory_capture_tb_top
  import osm_pkg::*;
;
  logic clk_i = 1'b0, rst_n_i, sample_valid_clr_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic sample_valid_o, op_tagged_i, op_retire_i, op_abort_i, load_op_flag_i, store_op_flag_i;
  logic locked_access_flag_i, uncacheable_access_flag_i, write_combining_access_flag_i;
  logic misaligned_penalty_flag_i, cache_miss_flag_i, tlb_hit_1g_page_i, tlb_hit_2m_page_i;
  logic tlb_miss_flag_i, miss_detect_i, miss_upper_i, data_return_i, return_upper_i;
  logic lin_addr_valid_i, phys_addr_valid_i, branch_op_i, branch_cond_not_taken_i;
  logic [63:0] lin_addr_i, branch_target_i, fall_through_i, reg_wdata_i, reg_rdata_o;
  logic [`OSM_PHYS_W-1:0] phys_addr_i;
  logic [`OSM_SEL_W-1:0]  reg_sel_i;
  osm_word_t exp_r [4];
  logic phys_known;
  int bad_count = 0, tests_run = 0, cycles = 0;

  osm_capture_regs uut (.*);
  osm_core_model core (.*);

  // Clock and hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic check(input string n, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  function automatic logic [63:0] canon(input logic [63:0] x);
    return {{16{x[47]}}, x[47:0]};
  endfunction

  // Expected cache sample word from the flags of the lower part
  function automatic logic [63:0] exp_dc(input logic [9:0] f, input int lat, input logic lv, pv);
    logic [15:0] l;
    l = (f[8] || !f[3]) ? 16'h0 : 16'(lat);
    return {16'h0, l, 13'h0, pv, lv, 1'b0, f[7:5], 4'h0, f[4:3], 1'b0, f[2:1], 1'b0, f[0],
            f[8], f[9]};
  endfunction

  task automatic rd(input logic [1:0] s, output logic [63:0] d);
    @(negedge clk_i);
    reg_sel_i = s;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    check("read_valid", {63'h0, reg_rvalid_o}, 64'h1);
    d = reg_rdata_o;
  endtask

  task automatic wr(input logic [1:0] s, input logic [63:0] d);
    @(negedge clk_i);
    {reg_sel_i, reg_wdata_i, reg_wr_i} = {s, d, 1'b1};
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    case (s)
      `OSM_SEL_DCACHE: exp_r[s] = d & `OSM_DCACHE_MASK;
      `OSM_SEL_PHYS: begin
        exp_r[s] = d & `OSM_PHYS_MASK;
        phys_known = 1'b1;
      end
      default: exp_r[s] = d;
    endcase
  endtask

  task automatic chk_all();
    logic [63:0] d;
    rd(`OSM_SEL_DCACHE, d);
    check("dcache_info", d, exp_r[0]);
    rd(`OSM_SEL_LIN, d);
    check("lin_addr", d, exp_r[1]);
    rd(`OSM_SEL_PHYS, d);
    if (phys_known) check("phys_addr", d, exp_r[2]);
    rd(`OSM_SEL_BRT, d);
    check("branch_target", d, exp_r[3]);
  endtask

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence: reset, software writes, then tagged ops
  initial begin
    logic [9:0] f;
    logic [63:0] la, bt, ft;
    logic [51:0] pa;
    logic ab, lv, pv, br, nt;
    int lat;
    void'($urandom(32'hd50c8d7a));
    {rst_n_i, sample_valid_clr_i, reg_wr_i, reg_rd_i, reg_sel_i, reg_wdata_i} = '0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    exp_r = '{default: 64'h0};
    phys_known = 1'b1;
    chk_all();
    for (int s = 0; s < 4; s++) wr(2'(s), {$urandom, $urandom});
    chk_all();
    for (int i = 0; i < 40; i++) begin
      f = (i < 10) ? 10'h1 << i : 10'($urandom);
      if (i == 10) f = 10'h108;
      lat = $urandom_range(0, 12);
      ab = (i > 10) && ($urandom_range(0, 3) == 0);
      {lv, pv, br, nt} = 4'($urandom);
      {la, bt, ft, pa} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
                          $urandom, 20'($urandom)};
      @(negedge clk_i) sample_valid_clr_i = 1'b1;
      @(negedge clk_i) sample_valid_clr_i = 1'b0;
      core.run_op(f, lat, ab, lv, pv, la, pa, br, nt, bt, ft);
      check("sample_valid", {63'h0, sample_valid_o}, {63'h0, !ab});
      if (!ab) begin
        exp_r[0] = exp_dc(f, lat, lv, pv);
        exp_r[1] = canon(la);
        exp_r[2] = {12'h0, pa};
        phys_known = pv;
        exp_r[3] = br ? canon(nt ? ft : bt) : 64'h0;
      end
      chk_all();
      if (i % 8 == 7) wr(2'($urandom), {$urandom, $urandom});
    end
    chk_all();
    stop_test();
  end
endmodule
`default_nettype wire
